/* File: rtl/itsaf_pkg.sv */
// What this block does
// - Frame-done flag requests a CPU interrupt per completed frame of continuous transfer.
// - Setting the frame-done flag also sets the combined interrupt flag, same cycle.
// - Slave mode: buffer empty/full rising sets frame-done only while second match is 1.
// - Master, clocked-sync and formatless modes: any buffer empty/full rise sets frame-done.
// - Frame-done clears on write 0 after reading it as 1; other status writes leave it.
// - Clearing the combined flag while the interface is enabled clears frame-done.
// - Slave receive: first frame after start matching seven second-address bits sets match.
// - Second address is recognised only while its format select bit is 0.
// - Match flag clears on write 0 after reading it as 1.
// - Any start condition on the bus clears the match flag.
// - In slave mode, a second-address match also sets the frame-done flag.
package itsaf_pkg;

  // Register byte offsets (word aligned)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_SADDR = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Status register field positions
  localparam int FD_BIT = 5;
  localparam int MATCH_BIT = 4;

  // Control register field positions
  localparam int EN_BIT = 0;
  localparam int MODE_LO = 1;
  localparam int COMB_BIT = 3;

  // Second address register: bits [7:1] address, bit 0 format select
  localparam int FMT_BIT = 0;
  localparam int SADDR_LO = 1;

  // Interrupt status / mask positions
  localparam int EVT_FD = 0;
  localparam int EVT_MATCH = 1;

  // Operating modes
  localparam logic [1:0] MODE_SLAVE = 2'h0;
  localparam logic [1:0] MODE_MASTER = 2'h1;
  localparam logic [1:0] MODE_CLKSYNC = 2'h2;
  localparam logic [1:0] MODE_NOFMT = 2'h3;

  // Reset values
  localparam logic [1:0] MODE_RST = MODE_SLAVE;
  localparam logic [6:0] SADDR_RST = 7'h00;
  localparam logic [1:0] MASK_RST = 2'h0;

  // Address frame: bits counted after start, last one is R/W
  localparam logic [2:0] ADDR_LAST = 3'h7;

endpackage

/* File: rtl/itsaf_link_if.sv */
`timescale 1ns/1ns
// Carries bus-watch controls and events between the core and the line watcher
interface itsaf_link_if;
  logic en;
  logic [6:0] saddr;
  logic fmt_sel;
  logic start;
  logic match;

  modport watch (input en, input saddr, input fmt_sel, output start, output match);
  modport core (output en, output saddr, output fmt_sel, input start, input match);
endinterface

/* File: rtl/itsaf_bus_watch.sv */
`timescale 1ns/1ns
// Watches SCL/SDA, finds start/stop and checks the first frame against the second address
module itsaf_bus_watch (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl_in,
  input wire logic sda_in,
  itsaf_link_if.watch lk
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic in_addr;
    logic [2:0] cnt;
    logic [6:0] sh;
    logic start;
    logic match;
  } itsaf_watch_s;

  itsaf_watch_s st_r;
  itsaf_watch_s st_nxt;
  logic start_c;
  logic stop_c;
  logic scl_rise;

  // Line conditions are judged only on second-stage samples
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_s1 = scl_in;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.scl_d = st_r.scl_s2;
    st_nxt.sda_s1 = sda_in;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.sda_d = st_r.sda_s2;
    start_c = st_r.scl_s2 & st_r.scl_d & st_r.sda_d & ~st_r.sda_s2;
    stop_c = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_d & st_r.sda_s2;
    scl_rise = st_r.scl_s2 & ~st_r.scl_d;
    st_nxt.start = start_c;
    st_nxt.match = 1'b0;
    if (start_c) begin
      st_nxt.in_addr = 1'b1;
      st_nxt.cnt = 3'h0;
    end else if (stop_c) begin
      st_nxt.in_addr = 1'b0; // Stop abandons a half-read address
    end else if (scl_rise && st_r.in_addr) begin
      st_nxt.cnt = st_r.cnt + 3'h1;
      if (st_r.cnt == itsaf_pkg::ADDR_LAST) begin
        // Seven address bits already shifted; this bit is R/W
        st_nxt.in_addr = 1'b0;
        st_nxt.match = lk.en & ~lk.fmt_sel & (st_r.sh == lk.saddr);
      end else begin
        st_nxt.sh = {st_r.sh[5:0], st_r.sda_s2};
      end
    end
  end

  // Lines idle high, so synchronisers reset to 1 to avoid a false start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lk.start = st_r.start;
  assign lk.match = st_r.match;

endmodule

/* File: rtl/itsaf_top.sv */
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
// Frame-done and second-address flags with an AHB-Lite register slave
module itsaf_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic tx_buf_empty_flag,
  input wire logic rx_buf_full_flag,
  output logic frame_done_irq_flag,
  output logic second_addr_match_flag,
  output logic combined_irq_flag,
  output logic irq
);

  typedef struct packed {
    logic frame_done;
    logic match;
    logic combined;
    logic iface_en;
    logic [1:0] mode;
    logic [6:0] saddr;
    logic fmt_sel;
    logic [1:0] evt;
    logic [1:0] mask;
    logic arm_fd;
    logic arm_match;
    logic tx_d;
    logic rx_d;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
    logic irq;
  } itsaf_top_s;

  // Slave is always ready and always answers OKAY
  localparam itsaf_top_s RST = '{
    mode: itsaf_pkg::MODE_RST,
    saddr: itsaf_pkg::SADDR_RST,
    mask: itsaf_pkg::MASK_RST,
    rdy: 1'b1,
    default: '0
  };

  itsaf_top_s st_r;
  itsaf_top_s st_nxt;
  itsaf_link_if lk ();

  logic wr_phase;
  logic rd_req;
  logic buf_rise;
  logic clr_fd;
  logic clr_match;
  logic clr_comb;
  logic set_fd;
  logic set_match;

  // Controls handed to the line watcher; only slave mode recognises addresses
  assign lk.en = st_r.iface_en & (st_r.mode == itsaf_pkg::MODE_SLAVE);
  assign lk.saddr = st_r.saddr;
  assign lk.fmt_sel = st_r.fmt_sel;

  itsaf_bus_watch u_watch (
    .hclk(hclk),
    .hresetn(hresetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .lk(lk.watch)
  );

  // Whole next-state computation; hardware sets always beat software clears
  always_comb begin
    st_nxt = st_r;
    clr_fd = 1'b0;
    clr_match = 1'b0;
    clr_comb = 1'b0;

    // Buffer flags come from same-clock logic; only their rising edge counts
    st_nxt.tx_d = tx_buf_empty_flag;
    st_nxt.rx_d = rx_buf_full_flag;
    buf_rise = (tx_buf_empty_flag & ~st_r.tx_d) | (rx_buf_full_flag & ~st_r.rx_d);

    // Data phase of a write: registers take hwdata now
    wr_phase = st_r.dp_valid & st_r.dp_write;
    if (wr_phase) begin
      if (st_r.dp_addr == itsaf_pkg::OFS_STATUS) begin
        // Writing 1 does nothing; 0 clears only a flag that was read as 1
        clr_fd = st_r.arm_fd & ~hwdata[itsaf_pkg::FD_BIT];
        clr_match = st_r.arm_match & ~hwdata[itsaf_pkg::MATCH_BIT];
        st_nxt.arm_fd = 1'b0;
        st_nxt.arm_match = 1'b0;
      end else if (st_r.dp_addr == itsaf_pkg::OFS_CTRL) begin
        st_nxt.iface_en = hwdata[itsaf_pkg::EN_BIT];
        st_nxt.mode = hwdata[itsaf_pkg::MODE_LO +: 2];
        clr_comb = ~hwdata[itsaf_pkg::COMB_BIT];
      end else if (st_r.dp_addr == itsaf_pkg::OFS_SADDR) begin
        st_nxt.saddr = hwdata[itsaf_pkg::SADDR_LO +: 7];
        st_nxt.fmt_sel = hwdata[itsaf_pkg::FMT_BIT];
      end else if (st_r.dp_addr == itsaf_pkg::OFS_IRQ_ST) begin
        st_nxt.evt = st_r.evt & ~hwdata[1:0];
      end else if (st_r.dp_addr == itsaf_pkg::OFS_IRQ_MASK) begin
        st_nxt.mask = hwdata[1:0];
      end
    end

    // Clearing the combined flag with the interface on also drops frame-done
    if (clr_comb && st_r.combined && st_r.iface_en) begin
      clr_fd = 1'b1;
    end

    // Match pulse already gated by slave mode, enable and format select
    set_match = lk.match;

    // Frame completion source depends on mode
    if (st_r.mode == itsaf_pkg::MODE_SLAVE) begin
      set_fd = (buf_rise & st_r.match) | set_match;
    end else begin
      set_fd = buf_rise;
    end

    st_nxt.frame_done = set_fd | (st_r.frame_done & ~clr_fd);
    st_nxt.combined = set_fd | (st_r.combined & ~clr_comb);
    st_nxt.match = set_match | (st_r.match & ~(clr_match | lk.start));

    // Sticky interrupt events, masked onto one level output
    st_nxt.evt[itsaf_pkg::EVT_FD] = st_nxt.evt[itsaf_pkg::EVT_FD] | set_fd;
    st_nxt.evt[itsaf_pkg::EVT_MATCH] = st_nxt.evt[itsaf_pkg::EVT_MATCH] | set_match;
    st_nxt.irq = |(st_nxt.evt & st_nxt.mask);

    // Address phase: capture and prepare read data from post-write state
    rd_req = hsel & hready & htrans[1];
    st_nxt.dp_valid = rd_req;
    st_nxt.dp_write = hwrite;
    st_nxt.dp_addr = haddr[7:0];
    st_nxt.rdata = 32'h0000_0000;
    if (rd_req && !hwrite) begin
      if (haddr[7:0] == itsaf_pkg::OFS_STATUS) begin
        st_nxt.rdata[itsaf_pkg::FD_BIT] = st_nxt.frame_done;
        st_nxt.rdata[itsaf_pkg::MATCH_BIT] = st_nxt.match;
        // A read arms the clear only for flags seen as 1
        st_nxt.arm_fd = st_nxt.frame_done;
        st_nxt.arm_match = st_nxt.match;
      end else if (haddr[7:0] == itsaf_pkg::OFS_CTRL) begin
        st_nxt.rdata[itsaf_pkg::EN_BIT] = st_nxt.iface_en;
        st_nxt.rdata[itsaf_pkg::MODE_LO +: 2] = st_nxt.mode;
        st_nxt.rdata[itsaf_pkg::COMB_BIT] = st_nxt.combined;
      end else if (haddr[7:0] == itsaf_pkg::OFS_SADDR) begin
        st_nxt.rdata[itsaf_pkg::SADDR_LO +: 7] = st_nxt.saddr;
        st_nxt.rdata[itsaf_pkg::FMT_BIT] = st_nxt.fmt_sel;
      end else if (haddr[7:0] == itsaf_pkg::OFS_IRQ_ST) begin
        st_nxt.rdata[1:0] = st_nxt.evt;
      end else if (haddr[7:0] == itsaf_pkg::OFS_IRQ_MASK) begin
        st_nxt.rdata[1:0] = st_nxt.mask;
      end
    end
  end

  // Single state register; flags start cleared
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // All outputs straight from the state register
  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.rdy;
  assign hresp = st_r.resp;
  assign frame_done_irq_flag = st_r.frame_done;
  assign second_addr_match_flag = st_r.match;
  assign combined_irq_flag = st_r.combined;
  assign irq = st_r.irq;

endmodule

/* File: verif/itsaf_checker.sv */
`timescale 1ns/1ns
// Ties flag outputs to bus writes, buffer events and line starts
module itsaf_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic tx_buf_empty_flag,
  input wire logic rx_buf_full_flag,
  input wire logic frame_done_irq_flag,
  input wire logic second_addr_match_flag,
  input wire logic combined_irq_flag,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Short names; frame-done may only fall two or three edges after a write, match also after a start
  wire fd = frame_done_irq_flag;
  wire ma = second_addr_match_flag;
  wire wr = hsel && htrans[1] && hwrite;
  fd_sets_comb_a: assert property ($rose(fd) |-> combined_irq_flag)
    else $error("frame flag rose alone");
  buf_sets_fd_a: assert property ($rose(tx_buf_empty_flag || rx_buf_full_flag)
    && ma && $past(ma) |-> ##[1:2] fd) else $error("buffer event missed");
  match_sets_fd_a: assert property ($rose(ma) |-> ##[0:2] fd)
    else $error("match did not set frame flag");
  start_clears_a: assert property ($fell(sda_in) && scl_in |-> ##[1:6] !ma)
    else $error("start left match flag set");
  fd_clear_a: assert property ($fell(fd) |-> $past(wr, 2) || $past(wr, 3))
    else $error("frame flag fell without a write");
  ma_clear_a: assert property ($fell(ma) |-> $past(wr, 2) || $past(wr, 3)
    || !$past(sda_in, 3)) else $error("match fell without cause");
  reset_zero_a: assert property (disable iff (1'h0) !hresetn |-> !fd && !ma && !irq)
    else $error("flags set in reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  cover property ($rose(ma));
  cover property ($rose(fd));
  cover property ($rose(irq));
endmodule

bind itsaf_top itsaf_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
  .scl_in(scl_in), .sda_in(sda_in), .tx_buf_empty_flag(tx_buf_empty_flag),
  .rx_buf_full_flag(rx_buf_full_flag), .frame_done_irq_flag(frame_done_irq_flag),
  .second_addr_match_flag(second_addr_match_flag),
  .combined_irq_flag(combined_irq_flag), .irq(irq));

/* File: verif/itsaf_i2c_mst.sv */
`timescale 1ns/1ns
// Far-side master; lines rest high as under pull-ups, clock still between frames
module itsaf_i2c_mst (
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  // Start, address byte at 320 ns a bit, then stop; no ack slot is needed
  task automatic frame(input logic [7:0] b);
    sda = 1'h0;
    #160;
    for (int i = 7; i >= 0; i--) begin
      scl = 1'h0;
      #80;
      sda = b[i];
      #80;
      scl = 1'h1;
      #160;
    end
    scl = 1'h0;
    #80;
    sda = 1'h0;
    #80;
    scl = 1'h1;
    #80;
    sda = 1'h1;
    #80;
  endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
// Flag block bench: bus tasks, line master, random picks among corner cases
module tb_top;
  logic hclk, hready, hreadyout, hresp, scl, sda, fd, ma, comb, irq;
  logic hresetn, hsel = 1'h1, hwrite = 1'h0, tx = 1'h0, rx = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [6:0] adr;
  int error_cnt, num_checks;
  itsaf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .sda_in(sda),
    .tx_buf_empty_flag(tx), .rx_buf_full_flag(rx), .frame_done_irq_flag(fd),
    .second_addr_match_flag(ma), .combined_irq_flag(comb), .irq(irq));
  itsaf_i2c_mst mst_u (.scl(scl), .sda(sda));
  // One slave only, so its ready is the bus ready
  assign hready = hreadyout;
  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Single word transfer; waits on ready in both phases, data taken at the last edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  // Writes leave two edges so the registered outputs have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
    repeat (2) @(posedge hclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'h0, a, $urandom);
    chk(q, e);
  endtask
  // Random mix of buffer events, one or both at once
  task automatic bump();
    {tx, rx} <= 2'($urandom_range(1, 3));
    @(posedge hclk);
    {tx, rx} <= 2'h0;
    repeat (3) @(posedge hclk);
  endtask
  // Address frame with a random direction bit, started off the clock edge
  task automatic frm(input logic [6:0] a);
    @(posedge hclk);
    #13;
    mst_u.frame({a, 1'($urandom_range(1))});
    repeat (4) @(posedge hclk);
  endtask
  function automatic logic [31:0] st(input logic f, input logic m);
    return (32'(f) << itsaf_pkg::FD_BIT) | (32'(m) << itsaf_pkg::MATCH_BIT);
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] md, input logic c);
    return 32'({c, md, 1'h1});
  endfunction
  initial begin
    #200_000;
    error_cnt++;
    final_report();
  end
  initial begin
    void'($urandom(39143));
    // Scheduled so that its falling edge reaches the asynchronous reset of the flops
    hresetn <= 1'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rdc(itsaf_pkg::OFS_STATUS, 32'h0);
    rdc(8'h20, 32'h0);
    wr(itsaf_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rdc(itsaf_pkg::OFS_STATUS, 32'h0);
    $display("test reset done");
    // Master, clocked and formatless: each event sets; unarmed write keeps it
    for (int m = 1; m < 4; m++) begin
      wr(itsaf_pkg::OFS_CTRL, ctl(2'(m), 1'h0));
      bump();
      chk(fd, 1'h1);
      chk(comb, 1'h1);
      wr(itsaf_pkg::OFS_STATUS, 32'h0);
      rdc(itsaf_pkg::OFS_STATUS, st(1'h1, 1'h0));
      wr(itsaf_pkg::OFS_STATUS, 32'h0);
      chk(fd, 1'h0);
      bump();
      wr(itsaf_pkg::OFS_CTRL, ctl(2'(m), 1'h0));
      chk(fd, 1'h0);
    end
    $display("test modes done");
    // Slave: format select, match, read-then-clear, start clearing
    adr = 7'($urandom);
    wr(itsaf_pkg::OFS_CTRL, ctl(itsaf_pkg::MODE_SLAVE, 1'h0));
    wr(itsaf_pkg::OFS_SADDR, {24'h00_0000, adr, 1'h1});
    frm(adr);
    chk(ma, 1'h0);
    bump();
    chk(fd, 1'h0);
    wr(itsaf_pkg::OFS_SADDR, {24'h00_0000, adr, 1'h0});
    frm(adr);
    chk(ma, 1'h1);
    rdc(itsaf_pkg::OFS_STATUS, st(1'h1, 1'h1));
    wr(itsaf_pkg::OFS_STATUS, st(1'h1, 1'h0));
    chk(ma, 1'h0);
    chk(fd, 1'h1);
    frm(adr);
    wr(itsaf_pkg::OFS_CTRL, ctl(itsaf_pkg::MODE_SLAVE, 1'h0));
    bump();
    chk(fd, 1'h1);
    frm(adr ^ 7'h55);
    chk(ma, 1'h0);
    $display("test slave done");
    // Pending events held back by the mask, then shown, then cleared
    chk(irq, 1'h0);
    wr(itsaf_pkg::OFS_IRQ_MASK, 32'h3);
    chk(irq, 1'h1);
    wr(itsaf_pkg::OFS_IRQ_ST, 32'h3);
    chk(irq, 1'h0);
    frm(adr);
    chk(irq, 1'h1);
    $display("test irq done");
    // Mid-run reset must drop every flag and the pending interrupt again
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk({fd, ma, comb, irq}, 32'h0);
    rdc(itsaf_pkg::OFS_STATUS, 32'h0);
    $display("test reset again done");
    final_report();
  end
endmodule
